// [design/sbt_map.vh]
// Functional notes
// R01: run bit starts sixteen-bit counting, clear stops
// R02: stop-in-idle halts counter during idle
// R03: external clock makes gate bit ignored
// R04: internal clock plus gate bit gates accumulation
// R05: prescale codes divide by 1,8,64,256
// R06: clock source picks pin edges or cycles
// R07: primary syncs external clock when sync set
// R08: pairing mode disables secondary run/gate/prescale/source
// R09: software clears secondary idle bit for pairing
// R10: unimplemented control bits read as zero
// R11: count per prescaled tick, gated while gate active
// R12: control bits reset to zero
`ifndef SBT_MAP_VH
`define SBT_MAP_VH
`define SBT_OFF_PRI_CTRL  4'h0
`define SBT_OFF_SEC_CTRL  4'h4
`define SBT_OFF_PRI_CNT   4'h8
`define SBT_OFF_SEC_CNT   4'hC
`define SBT_BIT_RUN       15
`define SBT_BIT_SIDL      13
`define SBT_BIT_GATE      6
`define SBT_BIT_PS_HI     5
`define SBT_BIT_PS_LO     4
`define SBT_BIT_PAIR      3
`define SBT_BIT_SYNC      2
`define SBT_BIT_CS        1
`define SBT_PRI_MASK      16'hA076
`define SBT_SEC_MASK      16'hA07A
`define SBT_CTRL_RESET    16'h0000
`define SBT_DIV_1         9'h000
`define SBT_DIV_8         9'h007
`define SBT_DIV_64        9'h03F
`define SBT_DIV_256       9'h0FF
`define SBT_RESP_OKAY     2'h0
`define SBT_RESP_SLVERR   2'h2
`endif

// [design/sbt_timer.v]
`timescale 1ns/1ns
`include "sbt_map.vh"
module sbt_timer
(
  input  wire        MCLK,
  input  wire        RST_N,
  input  wire        IDLE_MODE,
  input  wire        PRI_EXT_CLK_PIN,
  input  wire        SEC_EXT_CLK_PIN,
  input  wire        PRI_GATE_PIN,
  input  wire        SEC_GATE_PIN,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [3:0]  S_AXI_AWADDR,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  output reg  [1:0]  S_AXI_BRESP,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  input  wire [3:0]  S_AXI_ARADDR,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP
);

  // prescale code to terminal count of divider
  function [8:0] sbt_div_limit;
    input [1:0] code;
    begin
      case (code)
        2'b11:   sbt_div_limit = `SBT_DIV_256;
        2'b10:   sbt_div_limit = `SBT_DIV_64;
        2'b01:   sbt_div_limit = `SBT_DIV_8;
        default: sbt_div_limit = `SBT_DIV_1;
      endcase
    end
  endfunction

  // merge a 16-bit register with write strobes, masked to implemented bits
  function [15:0] sbt_wr;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    input [15:0] mask;
    begin
      sbt_wr = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]} & mask;
    end
  endfunction

  reg [15:0] pri_ctrl_q;   // primary control
  reg [15:0] sec_ctrl_q;   // secondary control
  reg [15:0] pri_cnt_q;    // primary counter
  reg [15:0] sec_cnt_q;    // secondary counter
  reg [8:0]  pri_pre_q;    // primary prescaler
  reg [8:0]  sec_pre_q;    // secondary prescaler
  // two-flop synchronisers, plus an edge history stage on the clock pins only
  reg [2:0]  pri_ck_q;
  reg [2:0]  sec_ck_q;
  reg [1:0]  idle_q;
  reg [1:0]  pri_gt_q;
  reg [1:0]  sec_gt_q;
  // extra history stage, used by the synchronised primary path only
  reg        pri_raw_q;

  wire idle = idle_q[1];
  wire pair = sec_ctrl_q[`SBT_BIT_PAIR];

  // a single-clock design cannot count truly asynchronously, so the pin
  // always passes two flops; sync off only drops one stage of latency
  wire pri_ext_sync = pri_ck_q[2] & ~pri_raw_q;
  wire pri_ext_fast = pri_ck_q[1] & ~pri_ck_q[2];
  wire pri_ext_edge = pri_ctrl_q[`SBT_BIT_SYNC] ? pri_ext_sync : pri_ext_fast; // R07
  wire sec_ext_edge = sec_ck_q[1] & ~sec_ck_q[2];

  // input tick: pin edge or every cycle
  wire pri_src = pri_ctrl_q[`SBT_BIT_CS] ? pri_ext_edge : 1'b1; // R06
  wire sec_src = sec_ctrl_q[`SBT_BIT_CS] ? sec_ext_edge : 1'b1; // R06

  // gate used only with internal clock
  wire pri_gate_ok = ~pri_ctrl_q[`SBT_BIT_GATE] | pri_ctrl_q[`SBT_BIT_CS] | pri_gt_q[1]; // R03 R04
  wire sec_gate_ok = ~sec_ctrl_q[`SBT_BIT_GATE] | sec_ctrl_q[`SBT_BIT_CS] | sec_gt_q[1]; // R03 R04

  // in pairing the secondary idle bit governs the pair
  wire pri_idle_stop = idle & (pair ? sec_ctrl_q[`SBT_BIT_SIDL] : pri_ctrl_q[`SBT_BIT_SIDL]); // R02 R09
  wire pri_run = pri_ctrl_q[`SBT_BIT_RUN] & ~pri_idle_stop & pri_gate_ok; // R01
  wire sec_run = sec_ctrl_q[`SBT_BIT_RUN] & ~(idle & sec_ctrl_q[`SBT_BIT_SIDL]) & sec_gate_ok & ~pair; // R08

  wire pri_tick = pri_run & pri_src;
  wire sec_tick = sec_run & sec_src;
  wire pri_inc  = pri_tick & (pri_pre_q == sbt_div_limit(pri_ctrl_q[`SBT_BIT_PS_HI:`SBT_BIT_PS_LO])); // R05
  wire sec_inc  = sec_tick & (sec_pre_q == sbt_div_limit(sec_ctrl_q[`SBT_BIT_PS_HI:`SBT_BIT_PS_LO])); // R05
  // in pairing the primary is the low half, carry feeds the secondary
  wire pri_carry = pri_inc & (pri_cnt_q == 16'hFFFF);

  // bus handshake state
  reg        aw_hold_q;
  reg [3:0]  aw_addr_q;
  reg        w_hold_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  wire do_wr = aw_hold_q & w_hold_q & ~S_AXI_BVALID;

  // synchronisers
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pri_ck_q  <= 3'h0;
      sec_ck_q  <= 3'h0;
      idle_q    <= 2'h0;
      pri_gt_q  <= 2'h0;
      sec_gt_q  <= 2'h0;
      pri_raw_q <= 1'b0;
    end
    else
    begin
      pri_ck_q  <= {pri_ck_q[1:0], PRI_EXT_CLK_PIN};
      sec_ck_q  <= {sec_ck_q[1:0], SEC_EXT_CLK_PIN};
      idle_q    <= {idle_q[0], IDLE_MODE};
      pri_gt_q  <= {pri_gt_q[0], PRI_GATE_PIN};
      sec_gt_q  <= {sec_gt_q[0], SEC_GATE_PIN};
      pri_raw_q <= pri_ck_q[2];
    end
  end

  // prescalers and counters
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pri_pre_q <= 9'h000;
      sec_pre_q <= 9'h000;
      pri_cnt_q <= 16'h0000;
      sec_cnt_q <= 16'h0000;
    end
    else
    begin
      // prescaler clears when timer is stopped
      if (!pri_ctrl_q[`SBT_BIT_RUN])
        pri_pre_q <= 9'h000;
      else if (pri_inc)
        pri_pre_q <= 9'h000;
      else if (pri_tick)
        pri_pre_q <= pri_pre_q + 9'h001; // R11
      if (!sec_ctrl_q[`SBT_BIT_RUN] || pair)
        sec_pre_q <= 9'h000;
      else if (sec_inc)
        sec_pre_q <= 9'h000;
      else if (sec_tick)
        sec_pre_q <= sec_pre_q + 9'h001; // R11
      // software writes win over counting
      if (do_wr && aw_addr_q == `SBT_OFF_PRI_CNT)
        pri_cnt_q <= sbt_wr(pri_cnt_q, w_data_q, w_strb_q, 16'hFFFF);
      else if (pri_inc)
        pri_cnt_q <= pri_cnt_q + 16'h0001; // R01 R11
      if (do_wr && aw_addr_q == `SBT_OFF_SEC_CNT)
        sec_cnt_q <= sbt_wr(sec_cnt_q, w_data_q, w_strb_q, 16'hFFFF);
      else if (pair ? pri_carry : sec_inc)
        sec_cnt_q <= sec_cnt_q + 16'h0001; // R11
    end
  end

  // write channel: address and data accepted in either order
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `SBT_RESP_OKAY;
      pri_ctrl_q    <= `SBT_CTRL_RESET; // R12
      sec_ctrl_q    <= `SBT_CTRL_RESET; // R12
    end
    else
    begin
      S_AXI_AWREADY <= ~aw_hold_q & ~S_AXI_AWREADY & ~S_AXI_BVALID;
      S_AXI_WREADY  <= ~w_hold_q & ~S_AXI_WREADY & ~S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (do_wr)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= `SBT_RESP_OKAY;
        case (aw_addr_q)
          `SBT_OFF_PRI_CTRL: pri_ctrl_q <= sbt_wr(pri_ctrl_q, w_data_q, w_strb_q, `SBT_PRI_MASK); // R10
          `SBT_OFF_SEC_CTRL: sec_ctrl_q <= sbt_wr(sec_ctrl_q, w_data_q, w_strb_q, `SBT_SEC_MASK); // R10
          `SBT_OFF_PRI_CNT:  S_AXI_BRESP <= `SBT_RESP_OKAY;
          `SBT_OFF_SEC_CNT:  S_AXI_BRESP <= `SBT_RESP_OKAY;
          default:           S_AXI_BRESP <= `SBT_RESP_SLVERR;
        endcase
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  // read channel: one cycle after address accept
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `SBT_RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= `SBT_RESP_OKAY;
        case (S_AXI_ARADDR)
          `SBT_OFF_PRI_CTRL: S_AXI_RDATA <= {16'h0000, pri_ctrl_q}; // R10
          `SBT_OFF_SEC_CTRL: S_AXI_RDATA <= {16'h0000, sec_ctrl_q}; // R10
          `SBT_OFF_PRI_CNT:  S_AXI_RDATA <= {16'h0000, pri_cnt_q};
          `SBT_OFF_SEC_CNT:  S_AXI_RDATA <= {16'h0000, sec_cnt_q};
          default:
          begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `SBT_RESP_SLVERR;
          end
        endcase
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

// [dv/sbt_timer_monitor.sv]
`timescale 1ns/1ns
module sbt_timer_monitor
(
  input wire        MCLK,
  input wire        RST_N,
  input wire        S_AXI_AWREADY,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire [1:0]  S_AXI_BRESP,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire [3:0]  S_AXI_ARADDR,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0]  S_AXI_RRESP
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  reg [3:0] ra_q; // offset of the read in flight
  // remember the read offset so data can be judged per register
  always @(posedge MCLK or negedge RST_N)
    if (!RST_N)
      ra_q <= 4'h0;
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
      ra_q <= S_AXI_ARADDR;
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_r_ans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_aw_pulse; S_AXI_AWREADY |=> !S_AXI_AWREADY; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready not a pulse");
  property p_ar_pulse; S_AXI_ARREADY |=> !S_AXI_ARREADY; endproperty
  a_ar_pulse: assert property (p_ar_pulse) else $error("arready not a pulse");
  property p_err_zero; S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h00000000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  // control words: unused positions except primary bit 0 must read zero
  property p_unimpl; S_AXI_RVALID && !ra_q[3] |-> S_AXI_RDATA[14] == 1'b0 && S_AXI_RDATA[12:7] == 6'h00; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused control bit set");
  property p_pri_pair; S_AXI_RVALID && ra_q == 4'h0 |-> S_AXI_RDATA[3] == 1'b0; endproperty
  a_pri_pair: assert property (p_pri_pair) else $error("pair bit on primary");
  property p_sec_sync; S_AXI_RVALID && ra_q == 4'h4 |-> S_AXI_RDATA[2] == 1'b0 && S_AXI_RDATA[0] == 1'b0; endproperty
  a_sec_sync: assert property (p_sec_sync) else $error("unused low bit set on secondary");
endmodule

// [dv/sbt_pin_model.sv]
`timescale 1ns/1ns
module sbt_pin_model
(
  input wire MCLK,
  output reg PIN
);
  initial PIN = 1'b0; // clock pin rests low between bursts
  // n rising edges, w cycles per phase: w=1 prompt, larger slow
  task automatic burst(input int n, input int w);
    repeat (n)
    begin
      repeat (w) @(posedge MCLK);
      PIN <= 1'b1;
      repeat (w) @(posedge MCLK);
      PIN <= 1'b0;
    end
  endtask
endmodule

// [dv/test_sixteen_bit_timer_control.sv]
`timescale 1ns/1ns
module test_sixteen_bit_timer_control;
  reg mclk = 0, rst_n = 0, idle = 0, gate = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  reg [3:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, seed = 32'h240E98D0, d, v;
  reg [1:0] r;
  wire awr, wr_r, bv, arr, rv, pin;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int errors = 0, samples_checked = 0, i;
  always #5 mclk = ~mclk;
  sbt_pin_model u_pin (.MCLK(mclk), .PIN(pin));
  sbt_timer DUT (.MCLK(mclk), .RST_N(rst_n), .IDLE_MODE(idle), .PRI_EXT_CLK_PIN(pin), .SEC_EXT_CLK_PIN(pin),
    .PRI_GATE_PIN(gate), .SEC_GATE_PIN(1'b0), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp));
  function automatic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input [31:0] got, input [31:0] exp, input string nm);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // address and data offered together, each dropped when taken
  task automatic wr(input [3:0] a, input [31:0] dt);
    bit ta, tw;
    ta = 0;
    tw = 0;
    awaddr <= a; wdata <= dt; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge mclk);
      if (!ta && awr) begin ta = 1; awv <= 1'b0; end
      if (!tw && wr_r) begin tw = 1; wv <= 1'b0; end
    end
    do @(posedge mclk); while (!bv);
    // ready lines stay high, so back-to-back calls never drive them twice in one step
    r = bresp;
  endtask
  task automatic rd(input [3:0] a);
    araddr <= a; arv <= 1'b1; rready <= 1'b1;
    do @(posedge mclk); while (!arr);
    arv <= 1'b0;
    do @(posedge mclk); while (!rv);
    d = rdata;
    r = rresp;
  endtask
  // clear counter, run w cycles with control c, stop, count must lie in lo..hi
  task automatic run(input [15:0] c, input int w, input int lo, input int hi, input string nm);
    wr(4'h8, 0);
    wr(4'h0, {16'h0, c});
    repeat (w) @(posedge mclk);
    wr(4'h0, 0);
    rd(4'h8);
    chk(d >= lo && d <= hi, 1, nm);
    $display("test %s done", nm);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(4'h0); chk(d, 0, "pri_ctrl_reset");
    rd(4'h4); chk(d, 0, "sec_ctrl_reset");
    repeat (4)
    begin
      v = xs();
      wr(4'h0, v); rd(4'h0); chk(d, v & 32'hA076, "pri_ctrl");
      wr(4'h4, v); rd(4'h4); chk(d, v & 32'hA07A, "sec_ctrl");
    end
    wr(4'h4, 0);
    // each prescale code: 40 ticks expected
    for (i = 0; i < 4; i++)
      run(16'h8000 | (i << 4), 40 << (3 * i - (i == 3)), i ? 39 : 36, i ? 41 : 44, "prescale");
    idle <= 1'b1;
    run(16'hA000, 40, 0, 1, "idle_stop");
    run(16'h8000, 40, 36, 44, "idle_run");
    idle <= 1'b0;
    run(16'h8040, 40, 0, 1, "gate_low");
    gate <= 1'b1;
    run(16'h8040, 40, 36, 44, "gate_high");
    gate <= 1'b0;
    // pin source with gate bit set and gate pin low: every edge counts
    for (i = 0; i < 2; i++)
    begin
      wr(4'h8, 0);
      wr(4'hC, 0);
      wr(4'h4, 32'h8042);
      wr(4'h0, 32'h8042 | (i << 2));
      u_pin.burst(10, i ? 1 : 3);
      repeat (8) @(posedge mclk);
      wr(4'h0, 0);
      wr(4'h4, 0);
      rd(4'h8);
      chk(d, 10, "ext_count");
      rd(4'hC);
      chk(d, 10, "sec_ext_count");
      $display("test ext_count done");
    end
    // pairing: secondary stop-in-idle left clear, own run bit ignored
    wr(4'hC, 0);
    wr(4'h4, 32'h8008);
    repeat (40) @(posedge mclk);
    rd(4'hC);
    chk(d, 0, "pair_sec");
    // low half preloaded near wrap: exactly one carry into the high half
    wr(4'h8, 32'hFFF0);
    wr(4'h0, 32'h8000);
    repeat (40) @(posedge mclk);
    wr(4'h0, 0);
    rd(4'hC);
    chk(d, 1, "pair_carry");
    // paired in idle: secondary idle bit clear keeps the pair running
    idle <= 1'b1;
    run(16'hA000, 40, 36, 44, "pair_idle");
    idle <= 1'b0;
    wr(4'h4, 0);
    rd(4'h2);
    chk(r, 2'h2, "unmapped_resp");
    chk(d, 0, "unmapped_data");
    wr(4'h2, 0);
    chk(r, 2'h2, "unmapped_bresp");
    $display("test pairing done");
    close_out();
  end
  initial
  begin
    repeat (60000) @(posedge mclk);
    errors++;
    close_out();
  end
endmodule
bind sbt_timer sbt_timer_monitor u_mon (.MCLK(MCLK), .RST_N(RST_N), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP));
